/* hdl/acs_defines.svh */
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
// register offsets (byte addresses)
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_PTR 8'h04
`define ACS_OFF_RES 8'h08
`define ACS_OFF_STAT 8'h0c
// control register bit positions
`define ACS_CTRL_START 0
`define ACS_CTRL_CAL 1
`define ACS_CTRL_CRST 2
`define ACS_CTRL_CFG_LSB 8
`define ACS_CTRL_CFG_MSB 26
// pointer register fields
`define ACS_PTR1_LSB 0
`define ACS_PTR2_LSB 4
// status register bits
`define ACS_STAT_FLAG 0
`define ACS_STAT_MASK 1
// reset values
`define ACS_DELAY_RST 8'h00
`define ACS_MASK_RST 1'b1
// timing
`define ACS_CLK_HZ 10000000
`define ACS_CLK_MHZ 10
`define ACS_TICK_HZ 32768
`define ACS_SYNC_NS 2000
`define ACS_SYNC_CYC ((`ACS_SYNC_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_RES_W 10
`define ACS_SLOTS 8
`endif

/* hdl/acs_pkg.sv */
package acs_pkg;
  // software configuration held in the control register, bits 26:8
  typedef struct packed {
    logic [2:0] switcher_pll_multiplier;
    logic [7:0] start_delay_count;
    logic charger_current_sense_enable;
    logic battery_current_sense_enable;
    logic second_pointer_autoinc;
    logic first_pointer_autoinc;
    logic input_buffer_enable;
    logic touch_input_map_select;
    logic delay_each_conversion;
    logic single_channel_mode;
  } acs_ctrl_t;

  typedef struct packed {
    logic [2:0] second_result_pointer;
    logic [2:0] first_result_pointer;
  } acs_ptr_t;

  typedef enum logic [2:0] {
    ACS_IDLE = 3'b000,
    ACS_PLL = 3'b001,
    ACS_SYNC = 3'b010,
    ACS_DLY = 3'b011,
    ACS_CONV = 3'b100,
    ACS_WAIT = 3'b101
  } acs_state_t;
endpackage : acs_pkg

/* hdl/acs_sequencer.sv */
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_sequencer (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic external_trigger_pin,
  input wire logic pll_ready,
  output logic pll_request,
  output logic conv_clk_strobe,
  output logic conv_start,
  output logic [2:0] conv_channel,
  output logic conv_calibrate,
  input wire logic conv_done,
  input wire logic [`ACS_RES_W-1:0] conv_result,
  output logic input_buffer_on,
  output logic conversion_done_irq,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////
  acs_pkg::acs_ctrl_t cfg_q;
  acs_pkg::acs_ptr_t ptr_q;
  acs_pkg::acs_state_t state_q;
  logic start_series_bit_q;
  logic calibration_request_q;
  logic conversion_done_flag_q;
  logic conversion_done_mask_q;
  logic [1:0] pend_q;
  logic [2:0] idx_q;
  logic cal_run_q;
  logic [7:0] sync_q;
  logic [8:0] dcnt_q;
  logic [23:0] nco_q;
  logic tick_q;
  logic [1:0] div_q;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_s3_q;
  logic [`ACS_RES_W-1:0] slot_q [`ACS_SLOTS];
  logic [31:0] rdata_q;

  logic ctrl_wr;
  logic ptr_wr;
  logic stat_wr;
  logic res_rd;
  logic core_reset;
  logic sw_start;
  logic trig_rise;
  logic new_req;
  logic accept;
  logic series_begin;
  logic series_done;
  logic store;
  logic [`ACS_RES_W-1:0] store_val;

  assign ctrl_wr = wr_stb && (addr == `ACS_OFF_CTRL);
  assign ptr_wr = wr_stb && (addr == `ACS_OFF_PTR);
  assign stat_wr = wr_stb && (addr == `ACS_OFF_STAT);
  assign res_rd = rd_stb && (addr == `ACS_OFF_RES);
  assign core_reset = ctrl_wr && wdata[`ACS_CTRL_CRST];
  assign sw_start = ctrl_wr && wdata[`ACS_CTRL_START];

  ////////////////////////////////////////////////////////////////////////
  // trigger pin: two-flop synchroniser, edge taken from the second and third stages
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= external_trigger_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_rise = trig_s2_q && !trig_s3_q;
  assign new_req = (sw_start || trig_rise) && !core_reset;
  // a full queue drops further requests rather than stalling the bus
  assign accept = new_req && (pend_q != 2'h2);

  ////////////////////////////////////////////////////////////////////////
  // time bases: the tick runs off the fixed core clock, so the PLL multiplier cannot move it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nco_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (nco_q + 24'(`ACS_TICK_HZ) >= 24'(`ACS_CLK_HZ)) begin
      nco_q <= nco_q + 24'(`ACS_TICK_HZ) - 24'(`ACS_CLK_HZ);
      tick_q <= 1'b1;
    end else begin
      nco_q <= nco_q + 24'(`ACS_TICK_HZ);
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_q <= 2'h0;
    end else begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    end
  end

  assign conv_clk_strobe = (div_q != 2'h2);

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  assign series_begin = (state_q == acs_pkg::ACS_IDLE) && (pend_q != 2'h0) && !core_reset;
  assign series_done = (state_q == acs_pkg::ACS_WAIT) && conv_done && (idx_q == 3'h7) && !core_reset;
  assign store = (state_q == acs_pkg::ACS_WAIT) && conv_done && !cal_run_q && !core_reset;

  always_ff @(posedge core_clk) begin
    if (srst || core_reset) begin
      state_q <= acs_pkg::ACS_IDLE;
      idx_q <= 3'h0;
      cal_run_q <= 1'b0;
      sync_q <= 8'h00;
      dcnt_q <= 9'h000;
    end else begin
      case (state_q)
        acs_pkg::ACS_IDLE: begin
          if (series_begin) begin
            state_q <= acs_pkg::ACS_PLL;
            idx_q <= 3'h0;
            cal_run_q <= calibration_request_q;
          end
        end
        acs_pkg::ACS_PLL: begin
          if (pll_ready) begin
            state_q <= acs_pkg::ACS_SYNC;
            sync_q <= 8'(`ACS_SYNC_CYC);
          end
        end
        acs_pkg::ACS_SYNC: begin
          if (sync_q <= 8'h01) begin
            state_q <= acs_pkg::ACS_DLY;
            dcnt_q <= {1'b0, cfg_q.start_delay_count} + 9'h001;
          end else begin
            sync_q <= sync_q - 8'h01;
          end
        end
        acs_pkg::ACS_DLY: begin
          if (tick_q) begin
            if (dcnt_q == 9'h001) begin
              state_q <= acs_pkg::ACS_CONV;
            end
            dcnt_q <= dcnt_q - 9'h001;
          end
        end
        acs_pkg::ACS_CONV: begin
          state_q <= acs_pkg::ACS_WAIT;
        end
        acs_pkg::ACS_WAIT: begin
          if (conv_done) begin
            if (idx_q == 3'h7) begin
              state_q <= acs_pkg::ACS_IDLE;
            end else if (cfg_q.delay_each_conversion) begin
              state_q <= acs_pkg::ACS_DLY;
              dcnt_q <= {1'b0, cfg_q.start_delay_count} + 9'h001;
            end else begin
              state_q <= acs_pkg::ACS_CONV;
            end
            idx_q <= idx_q + 3'h1;
          end
        end
        default: begin
          state_q <= acs_pkg::ACS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || core_reset) begin
      pend_q <= 2'h0;
    end else begin
      pend_q <= pend_q + {1'b0, accept} - {1'b0, series_done};
    end
  end

  // channel 0..7 in order, or the first pointer's channel eight times
  assign conv_channel = cfg_q.single_channel_mode ? ptr_q.first_result_pointer : idx_q;
  assign conv_start = (state_q == acs_pkg::ACS_CONV);
  assign conv_calibrate = cal_run_q && (state_q != acs_pkg::ACS_IDLE);
  assign pll_request = (state_q != acs_pkg::ACS_IDLE) || (pend_q != 2'h0);
  assign busy = (state_q != acs_pkg::ACS_IDLE);
  assign input_buffer_on = cfg_q.input_buffer_enable
    && ((state_q == acs_pkg::ACS_CONV) || (state_q == acs_pkg::ACS_WAIT));

  ////////////////////////////////////////////////////////////////////////
  // results: disabled sense paths and unmapped channels read as zero
  always_comb begin
    store_val = conv_result;
    if (cfg_q.touch_input_map_select && !conv_channel[2]) begin
      store_val = '0;
    end else if (!cfg_q.touch_input_map_select) begin
      if (conv_channel == 3'h1 && !cfg_q.battery_current_sense_enable) begin
        store_val = '0;
      end
      if (conv_channel == 3'h4 && !cfg_q.charger_current_sense_enable) begin
        store_val = '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `ACS_SLOTS; i++) begin
        slot_q[i] <= '0;
      end
    end else if (store) begin
      slot_q[idx_q] <= store_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= '{start_delay_count: `ACS_DELAY_RST, default: '0};
    end else if (ctrl_wr) begin
      cfg_q <= acs_pkg::acs_ctrl_t'(wdata[`ACS_CTRL_CFG_MSB:`ACS_CTRL_CFG_LSB]);
    end
  end

  // start bit: set by a write or by a pin-started series, cleared when nothing is left
  always_ff @(posedge core_clk) begin
    if (srst || core_reset) begin
      start_series_bit_q <= 1'b0;
    end else if (accept || series_begin) begin
      start_series_bit_q <= 1'b1;
    end else if (series_done && pend_q == 2'h1) begin
      start_series_bit_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      calibration_request_q <= 1'b0;
    end else if (ctrl_wr) begin
      calibration_request_q <= wdata[`ACS_CTRL_CAL];
    end else if (series_done && cal_run_q) begin
      calibration_request_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      conversion_done_flag_q <= 1'b0;
      conversion_done_mask_q <= `ACS_MASK_RST;
    end else begin
      if (series_done) begin
        conversion_done_flag_q <= 1'b1;
      end else if (stat_wr && wdata[`ACS_STAT_FLAG]) begin
        conversion_done_flag_q <= 1'b0;
      end
      if (stat_wr) begin
        conversion_done_mask_q <= wdata[`ACS_STAT_MASK];
      end
    end
  end

  assign conversion_done_irq = conversion_done_flag_q && !conversion_done_mask_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_q <= '0;
    end else if (ptr_wr) begin
      ptr_q.first_result_pointer <= wdata[`ACS_PTR1_LSB +: 3];
      ptr_q.second_result_pointer <= wdata[`ACS_PTR2_LSB +: 3];
    end else if (res_rd) begin
      // 3-bit add wraps 7 to 0 by itself
      if (cfg_q.first_pointer_autoinc) begin
        ptr_q.first_result_pointer <= ptr_q.first_result_pointer + 3'h1;
      end
      if (cfg_q.second_pointer_autoinc) begin
        ptr_q.second_result_pointer <= ptr_q.second_result_pointer + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `ACS_OFF_CTRL: rdata_q <= {5'h00, cfg_q, 5'h00, 1'b0, calibration_request_q, start_series_bit_q};
        `ACS_OFF_PTR: rdata_q <= {25'h0000000, ptr_q.second_result_pointer, 1'b0, ptr_q.first_result_pointer};
        `ACS_OFF_RES: rdata_q <= {12'h000, slot_q[ptr_q.second_result_pointer],
                                  slot_q[ptr_q.first_result_pointer]};
        `ACS_OFF_STAT: rdata_q <= {26'h0000000, pend_q, pll_request, busy,
                                   conversion_done_mask_q, conversion_done_flag_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking acs_cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_issue;
    (state_q == acs_pkg::ACS_CONV) ##1 (state_q == acs_pkg::ACS_WAIT);
  endsequence

  sequence s_sync_to_delay;
    (state_q == acs_pkg::ACS_SYNC) ##1 (state_q == acs_pkg::ACS_DLY);
  endsequence

  AST_QUEUE_DEPTH: assert property (pend_q <= 2'h2)
    else $error("request queue exceeds two");
  AST_DONE_FLAG: assert property (series_done |=> conversion_done_flag_q)
    else $error("done flag not raised at series end");
  AST_MASK_BLOCKS: assert property (conversion_done_mask_q |-> !conversion_done_irq)
    else $error("masked done flag forwarded");
  AST_TRIG_START: assert property (trig_rise && pend_q == 2'h0 && !core_reset |=> start_series_bit_q)
    else $error("pin start did not set start bit");
  AST_EIGHT_CONV: assert property (conv_start && idx_q == 3'h7 |-> s_issue)
    else $error("last conversion not issued properly");
  AST_DELAY_LOAD: assert property (s_sync_to_delay |-> dcnt_q == {1'b0, cfg_q.start_delay_count} + 9'h001)
    else $error("start delay loaded with wrong count");
  AST_CAL_CLEAR: assert property (series_done && cal_run_q && !ctrl_wr |=> !calibration_request_q)
    else $error("calibration request not cleared");
  AST_NO_CAL_STORE: assert property (cal_run_q && busy |-> !store)
    else $error("calibration wrote a result slot");
  AST_AUTOINC: assert property (res_rd && !ptr_wr && cfg_q.first_pointer_autoinc
    |=> ptr_q.first_result_pointer == $past(ptr_q.first_result_pointer) + 3'h1)
    else $error("first pointer did not advance");
  AST_BUF_GATE: assert property (input_buffer_on |-> busy && cfg_q.input_buffer_enable)
    else $error("input buffer on outside conversion");
  AST_PLL_HELD: assert property (busy |-> pll_request)
    else $error("pll released during series");
  AST_START_CLEAR: assert property (series_done && pend_q == 2'h1 && !accept |=> !start_series_bit_q)
    else $error("start bit not cleared at last series end");
  AST_CORE_RESET: assert property (core_reset |=> !busy && pend_q == 2'h0)
    else $error("core reset left the sequencer running");

endmodule : acs_sequencer

/* testbench/acs_core_model.sv */
`timescale 1ns/1ps
// converter core and switcher pll stand-in; answers promptly or slowly on command
module acs_core_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic pll_request,
  output logic pll_ready,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic conv_calibrate,
  input wire logic slow,
  input wire logic [6:0] salt,
  output logic conv_done,
  output logic [9:0] conv_result
);
  logic [3:0] pll_cnt_q;
  logic [4:0] left_q;
  logic [9:0] val_q;
  ////////////////////////////////////////////////////////////////
  // pll needs a few cycles to lock after being asked for
  always_ff @(posedge core_clk) begin
    if (srst || !pll_request) pll_cnt_q <= 4'h0;
    else if (pll_cnt_q != 4'h5) pll_cnt_q <= pll_cnt_q + 4'h1;
  end
  assign pll_ready = (pll_cnt_q == 4'h5);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    conv_done <= 1'b0;
    if (srst) left_q <= 5'h00;
    else if (conv_start) left_q <= slow ? 5'h0c : 5'h02;
    else if (left_q != 5'h00) begin
      left_q <= left_q - 5'h01;
      conv_done <= (left_q == 5'h01);
    end
    if (conv_start) val_q <= conv_calibrate ? 10'h3ff : {salt, conv_channel};
  end
  // result is only meaningful with the done pulse; garbage otherwise
  assign conv_result = conv_done ? val_q : ~val_q;
endmodule : acs_core_model

/* testbench/adc_conversion_sequencer_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module adc_conversion_sequencer_bench;
  logic core_clk, srst, wr_stb, rd_stb, external_trigger_pin, slow;
  logic pll_ready, pll_request, conv_clk_strobe, conv_start, conv_calibrate, conv_done;
  logic input_buffer_on, conversion_done_irq, busy;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [2:0] conv_channel;
  logic [9:0] conv_result;
  logic [6:0] salt;
  logic [9:0] exp_q [8];
  int bad_count, n_compared, cyc, n_starts, t0, first_s, last_s, viol, tot, strb, n_cal;
  bit buf_seen;

  acs_sequencer uut (.core_clk(core_clk), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .external_trigger_pin(external_trigger_pin), .pll_ready(pll_ready),
    .pll_request(pll_request), .conv_clk_strobe(conv_clk_strobe), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_calibrate(conv_calibrate), .conv_done(conv_done),
    .conv_result(conv_result), .input_buffer_on(input_buffer_on),
    .conversion_done_irq(conversion_done_irq), .busy(busy));
  acs_core_model partner (.core_clk(core_clk), .srst(srst), .pll_request(pll_request), .pll_ready(pll_ready),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_calibrate(conv_calibrate), .slow(slow),
    .salt(salt), .conv_done(conv_done), .conv_result(conv_result));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cyc++;
    if (conv_start === 1'b1) begin
      if (n_starts == 0) first_s = cyc;
      if (conv_calibrate === 1'b1) n_cal++;
      last_s = cyc;
      n_starts++;
    end
    if (input_buffer_on === 1'b1) begin
      buf_seen = 1;
      if (busy !== 1'b1) viol++;
    end
    if (srst === 1'b0) begin
      tot++;
      if (conv_clk_strobe === 1'b1) strb++;
    end
    // a hang counts as a mismatch
    if (cyc == 60000) begin
      bad_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(negedge core_clk);
    v = rdata;
    @(posedge core_clk);
  endtask : rd

  function automatic logic [31:0] cw(acs_pkg::acs_ctrl_t c, logic [2:0] low);
    return {5'h00, c, 5'h00, low};
  endfunction : cw

  function automatic logic [9:0] ev(int ch, acs_pkg::acs_ctrl_t c, logic [6:0] s);
    if (c.touch_input_map_select && ch < 4) return 10'h000;
    if (!c.touch_input_map_select && ((ch == 1 && !c.battery_current_sense_enable) ||
        (ch == 4 && !c.charger_current_sense_enable))) return 10'h000;
    return {s, 3'(ch)};
  endfunction : ev

  task automatic wait_idle;
    int i;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 20000 && (busy !== 1'b0 || pll_request !== 1'b0); i++) @(posedge core_clk);
  endtask : wait_idle

  task automatic series(input acs_pkg::acs_ctrl_t c, input logic cal);
    logic [31:0] v;
    int lat;
    n_starts = 0;
    t0 = cyc;
    wr(8'h00, cw(c, {1'b0, cal, 1'b1}));
    `CHK("pll_request", 1'b1, pll_request)
    wait_idle();
    `CHK("conversions", 8, n_starts)
    lat = first_s - t0;
    `CHK("start latency", 1'b1, lat >= 20 + c.start_delay_count * 300 && lat <= 80 + (c.start_delay_count + 1) * 310)
    if (c.delay_each_conversion) `CHK("spread", 1'b1, last_s - first_s >= 2100)
    else `CHK("spread", 1'b1, last_s - first_s <= 300)
    rd(8'h00, v);
    `CHK("start bit", 1'b0, v[0])
    `CHK("cal bit", 1'b0, v[1])
    rd(8'h0c, v);
    `CHK("done flag", 1'b1, v[0])
  endtask : series

  // reads all eight slots through both auto-incrementing pointers
  task automatic chk_slots(input logic [2:0] p);
    logic [31:0] v;
    int i;
    wr(8'h04, {25'h0, p + 3'd3, 1'b0, p});
    for (i = 0; i < 8; i++) begin
      rd(8'h08, v);
      `CHK("first value", exp_q[3'(p + i)], v[9:0])
      `CHK("second value", exp_q[3'(p + 3 + i)], v[19:10])
    end
  endtask : chk_slots
  ////////////////////////////////////////////////////////////////
  initial begin
    acs_pkg::acs_ctrl_t c;
    logic [31:0] v;
    logic [2:0] p;
    int j;
    int k;
    srst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    external_trigger_pin = 1'b0;
    slow = 1'b0;
    salt = 7'h00;
    {bad_count, n_compared, cyc, n_starts, viol, tot, strb, n_cal} = '0;
    buf_seen = 0;
    k = $urandom(78608);
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd(8'h0c, v);
    `CHK("mask reset", 2'b10, v[1:0])
    rd(8'h00, v);
    `CHK("delay reset", 8'h00, v[23:16])
    rd(8'h10, v);
    `CHK("unmapped", 32'h0, v)
    for (j = 0; j < 6; j++) begin
      c = 19'($urandom);
      c.start_delay_count = 8'($urandom % 2);
      c.delay_each_conversion = (j == 5);
      c.single_channel_mode = j[0];
      c.first_pointer_autoinc = 1'b1;
      c.second_pointer_autoinc = 1'b1;
      c.input_buffer_enable = 1'b1;
      p = 3'($urandom);
      salt <= 7'($urandom);
      slow <= 1'($urandom);
      wr(8'h04, {29'h0, p});
      series(c, 1'b0);
      for (k = 0; k < 8; k++) exp_q[k] = ev(c.single_channel_mode ? int'(p) : k, c, salt);
      chk_slots(3'($urandom));
      if (j == 0) begin
        `CHK("irq masked", 1'b0, conversion_done_irq)
        wr(8'h0c, 32'h0);
        `CHK("irq unmasked", 1'b1, conversion_done_irq)
        wr(8'h0c, 32'h1);
        `CHK("irq cleared", 1'b0, conversion_done_irq)
      end
    end
    // two requests back to back must both run
    // chk_slots moved pointer one; single channel mode must convert the same channel as before
    wr(8'h04, {29'h0, p});
    n_starts = 0;
    wr(8'h00, cw(c, 3'b001));
    wr(8'h00, cw(c, 3'b001));
    wait_idle();
    `CHK("queued conversions", 16, n_starts)
    salt <= salt + 7'h01;
    series(c, 1'b1);
    `CHK("cal conversions", 8, n_cal)
    chk_slots(3'h0);
    external_trigger_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    external_trigger_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(8'h00, v);
    `CHK("pin start bit", 1'b1, v[0])
    // pointer one is back at 0 after chk_slots, so a single channel series converts channel 0
    for (k = 0; k < 8; k++) exp_q[k] = ev(c.single_channel_mode ? 0 : k, c, salt);
    wait_idle();
    rd(8'h00, v);
    `CHK("pin start cleared", 1'b0, v[0])
    wr(8'h00, cw(c, 3'b001));
    // abort before the first tick so that no conversion can overwrite a slot
    repeat (5) @(posedge core_clk);
    `CHK("busy before core reset", 1'b1, busy)
    wr(8'h00, cw(c, 3'b100));
    repeat (3) @(posedge core_clk);
    `CHK("core reset busy", 1'b0, busy)
    rd(8'h00, v);
    `CHK("core reset config", c, v[26:8])
    chk_slots(3'h1);
    `CHK("buffer off when idle", 0, viol)
    `CHK("buffer used", 1'b1, buf_seen)
    `CHK("strobe ratio", 1'b1, 3 * strb - 2 * tot <= 3 && 2 * tot - 3 * strb <= 3)
    close_out();
  end
endmodule : adc_conversion_sequencer_bench
